//--- verilog/uvr_pkg.sv
/*
 * Constants and carrier types for the vendor register access block.
 * Assumes a USB device core that hands over decoded SETUP packets.
 */
package uvr_pkg;

	// ****************************************
	// Request encodings
	// ****************************************
	localparam logic [7:0]  REQ_TYPE_READ   = 8'hC0;
	localparam logic [7:0]  REQ_TYPE_WRITE  = 8'h40;
	localparam logic [7:0]  REQ_CODE_READ   = 8'h0D;
	localparam logic [7:0]  REQ_CODE_WRITE  = 8'h0E;
	localparam logic [15:0] LEN_READ        = 16'h0001;
	localparam logic [15:0] LEN_WRITE       = 16'h0000;

	// ****************************************
	// Application numbers (wValue high byte)
	// ****************************************
	localparam logic [7:0] APP_CONTROL = 8'h00;
	localparam logic [7:0] APP_PRINTER = 8'h01;
	localparam logic [7:0] APP_UART    = 8'h02;

	// ****************************************
	// Printer port offsets
	// ****************************************
	localparam logic [15:0] PP_OFS_DATA    = 16'h0000;
	localparam logic [15:0] PP_OFS_STATUS  = 16'h0001;
	localparam logic [15:0] PP_OFS_CONTROL = 16'h0002;
	localparam logic [15:0] PP_OFS_FIFO_A  = 16'h0008;
	localparam logic [15:0] PP_OFS_CONF_B  = 16'h0009;
	localparam logic [15:0] PP_OFS_EXT     = 16'h000A;

	// ****************************************
	// UART offsets and fields
	// ****************************************
	localparam logic [15:0] UA_OFS_HOLD   = 16'h0000;
	localparam logic [15:0] UA_OFS_IEN    = 16'h0001;
	localparam logic [15:0] UA_OFS_FIID   = 16'h0002;
	localparam logic [15:0] UA_OFS_LINE   = 16'h0003;
	localparam logic [15:0] UA_OFS_MODEM  = 16'h0004;
	localparam logic [15:0] UA_OFS_LSTAT  = 16'h0005;
	localparam logic [15:0] UA_OFS_MSTAT  = 16'h0006;
	localparam logic [15:0] UA_OFS_SCR    = 16'h0007;
	localparam int          LINE_DLAB_BIT = 7;

	// ****************************************
	// Control application offsets
	// ****************************************
	localparam logic [15:0] CT_OFS_BAUD  = 16'h0000;
	localparam logic [15:0] CT_OFS_FLOW  = 16'h0001;
	localparam logic [15:0] CT_OFS_CLOCK = 16'h0002;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [7:0]  RST_BYTE    = 8'h00;
	localparam logic [15:0] RST_DIVISOR = 16'h0000;

	typedef struct packed {
		logic [7:0]  req_type;
		logic [7:0]  req_code;
		logic [15:0] value;
		logic [15:0] index;
		logic [15:0] length;
	} uvr_setup_type;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_EXEC  = 3'b010,
		ST_REPLY = 3'b100
	} uvr_state_type;

endpackage

//--- verilog/uvr_top.sv
/*
 * Vendor request interpreter: turns SETUP requests into single byte
 * register reads and writes of the printer port, UART and control set.
 * Assumes the USB core holds setup_valid until setup_ready and reads
 * the reply pulse; UART engine supplies status bytes on the same clock.
 */
`timescale 1ns/100ps

module uvr_top
	import uvr_pkg::*;
(
	// Clock and reset
	input  wire logic          clk,
	input  wire logic          rst,
	// Setup request from USB core
	input  wire uvr_setup_type setup,
	input  wire logic          setup_valid,
	output logic               setup_ready,
	// Answer to USB core
	output logic               reply_valid,
	output logic               reply_stall,
	output logic [7:0]         reply_data,
	// UART side status inputs
	input  wire logic [7:0]    uart_rx_data,
	input  wire logic [7:0]    uart_int_ident,
	input  wire logic [7:0]    uart_line_status,
	input  wire logic [7:0]    uart_modem_status,
	// UART side register outputs
	output logic [7:0]         tx_data,
	output logic               tx_load,
	output logic               rx_taken,
	output logic [15:0]        divisor,
	output logic [7:0]         fifo_ctl,
	output logic               fifo_ctl_load
);

	// ****************************************
	// Registers
	// ****************************************
	uvr_state_type state_r;
	uvr_setup_type req_r;
	logic [7:0]    pp_data_r, pp_status_r, pp_control_r;
	logic [7:0]    pp_fifo_r, printer_config_b_r, pp_ext_r;
	logic [7:0]    ien_r, line_r, modem_r, lstat_w_r, mstat_w_r, scr_r;
	logic [15:0]   divisor_r;
	logic [7:0]    ct_baud_r, ct_flow_r, ct_clock_r;

	// ****************************************
	// Request decode
	// ****************************************
	logic       is_read, is_write, dlab, known, rd_hit;
	logic [7:0] app, wbyte, rd_val;
	logic [15:0] ofs;

	assign app   = req_r.value[15:8];
	assign wbyte = req_r.value[7:0];
	assign ofs   = req_r.index;
	assign dlab  = line_r[LINE_DLAB_BIT];
	assign is_read  = req_r.req_type == REQ_TYPE_READ && req_r.req_code == REQ_CODE_READ
		&& req_r.length == LEN_READ;
	assign is_write = req_r.req_type == REQ_TYPE_WRITE && req_r.req_code == REQ_CODE_WRITE
		&& req_r.length == LEN_WRITE;

	always_comb begin
		rd_hit = 1'b1;
		rd_val = RST_BYTE;
		unique case (app)
			APP_PRINTER: begin
				unique case (ofs)
					PP_OFS_DATA:    rd_val = pp_data_r;
					PP_OFS_STATUS:  rd_val = pp_status_r;
					PP_OFS_CONTROL: rd_val = pp_control_r;
					PP_OFS_FIFO_A:  rd_val = pp_fifo_r;
					PP_OFS_CONF_B:  rd_val = printer_config_b_r;
					PP_OFS_EXT:     rd_val = pp_ext_r;
					default:        rd_hit = 1'b0;
				endcase
			end
			APP_UART: begin
				unique case (ofs)
					UA_OFS_HOLD:  rd_val = dlab ? divisor_r[7:0] : uart_rx_data;
					UA_OFS_IEN:   rd_val = dlab ? divisor_r[15:8] : ien_r;
					UA_OFS_FIID:  rd_val = uart_int_ident;
					UA_OFS_LINE:  rd_val = line_r;
					UA_OFS_MODEM: rd_val = modem_r;
					UA_OFS_LSTAT: rd_val = uart_line_status;
					UA_OFS_MSTAT: rd_val = uart_modem_status;
					UA_OFS_SCR:   rd_val = scr_r;
					default:      rd_hit = 1'b0;
				endcase
			end
			APP_CONTROL: begin
				unique case (ofs)
					CT_OFS_BAUD:  rd_val = ct_baud_r;
					CT_OFS_FLOW:  rd_val = ct_flow_r;
					CT_OFS_CLOCK: rd_val = ct_clock_r;
					default:      rd_hit = 1'b0;
				endcase
			end
			default: rd_hit = 1'b0;
		endcase
	end

	// Offset maps are identical for both directions
	assign known = (is_read || is_write) && rd_hit;

	logic do_wr;
	assign do_wr = state_r == ST_EXEC && is_write && known;

	// ****************************************
	// Sequencer
	// ****************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			state_r <= ST_IDLE;
			req_r   <= '0;
		end else begin
			unique case (state_r)
				ST_IDLE: if (setup_valid) begin
					req_r   <= setup;
					state_r <= ST_EXEC;
				end
				ST_EXEC:  state_r <= ST_REPLY;
				ST_REPLY: state_r <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			setup_ready <= 1'b0;
			reply_valid <= 1'b0;
			reply_stall <= 1'b0;
			reply_data  <= RST_BYTE;
			rx_taken    <= 1'b0;
		end else begin
			setup_ready <= state_r == ST_IDLE && setup_valid && !setup_ready;
			reply_valid <= state_r == ST_EXEC;
			reply_stall <= state_r == ST_EXEC && !known;
			reply_data  <= (state_r == ST_EXEC && is_read && known) ? rd_val : RST_BYTE;
			rx_taken    <= state_r == ST_EXEC && is_read && known && app == APP_UART
				&& ofs == UA_OFS_HOLD && !dlab;
		end
	end

	// ****************************************
	// Printer port registers
	// ****************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			pp_data_r    <= RST_BYTE;
			pp_status_r  <= RST_BYTE;
			pp_control_r <= RST_BYTE;
			pp_fifo_r    <= RST_BYTE;
			printer_config_b_r  <= RST_BYTE;
			pp_ext_r     <= RST_BYTE;
		end else if (do_wr && app == APP_PRINTER) begin
			unique case (ofs)
				PP_OFS_DATA:    pp_data_r    <= wbyte;
				PP_OFS_STATUS:  pp_status_r  <= wbyte;
				PP_OFS_CONTROL: pp_control_r <= wbyte;
				PP_OFS_FIFO_A:  pp_fifo_r    <= wbyte;
				PP_OFS_CONF_B:  printer_config_b_r  <= wbyte;
				PP_OFS_EXT:     pp_ext_r     <= wbyte;
				default: ;
			endcase
		end
	end

	// ****************************************
	// UART registers
	// ****************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			ien_r         <= RST_BYTE;
			line_r        <= RST_BYTE;
			modem_r       <= RST_BYTE;
			lstat_w_r     <= RST_BYTE;
			mstat_w_r     <= RST_BYTE;
			scr_r         <= RST_BYTE;
			divisor_r     <= RST_DIVISOR;
			tx_data       <= RST_BYTE;
			tx_load       <= 1'b0;
			fifo_ctl      <= RST_BYTE;
			fifo_ctl_load <= 1'b0;
		end else begin
			tx_load       <= 1'b0;
			fifo_ctl_load <= 1'b0;
			if (do_wr && app == APP_UART) begin
				unique case (ofs)
					UA_OFS_HOLD: if (dlab) divisor_r[7:0] <= wbyte;
						else begin
							tx_data <= wbyte;
							tx_load <= 1'b1;
						end
					UA_OFS_IEN: if (dlab) divisor_r[15:8] <= wbyte;
						else ien_r <= wbyte;
					UA_OFS_FIID: begin
						fifo_ctl      <= wbyte;
						fifo_ctl_load <= 1'b1;
					end
					UA_OFS_LINE:  line_r    <= wbyte;
					UA_OFS_MODEM: modem_r   <= wbyte;
					UA_OFS_LSTAT: lstat_w_r <= wbyte;
					UA_OFS_MSTAT: mstat_w_r <= wbyte;
					UA_OFS_SCR:   scr_r     <= wbyte;
					default: ;
				endcase
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst)
			divisor <= RST_DIVISOR;
		else
			divisor <= divisor_r;
	end

	// ****************************************
	// Control application registers
	// ****************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			ct_baud_r  <= RST_BYTE;
			ct_flow_r  <= RST_BYTE;
			ct_clock_r <= RST_BYTE;
		end else if (do_wr && app == APP_CONTROL) begin
			unique case (ofs)
				CT_OFS_BAUD:  ct_baud_r  <= wbyte;
				CT_OFS_FLOW:  ct_flow_r  <= wbyte;
				CT_OFS_CLOCK: ct_clock_r <= wbyte;
				default: ;
			endcase
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	property p_read_len;
		@(posedge clk) disable iff (rst)
		(state_r == ST_EXEC && req_r.length != LEN_READ && req_r.req_code == REQ_CODE_READ)
			|=> reply_stall;
	endproperty
	a_read_len: assert property (p_read_len) else $error("bad read length not stalled");

	property p_write_len;
		@(posedge clk) disable iff (rst)
		(state_r == ST_EXEC && req_r.req_code == REQ_CODE_WRITE && req_r.length != LEN_WRITE)
			|=> reply_stall;
	endproperty
	a_write_len: assert property (p_write_len) else $error("bad write length not stalled");

	property p_scr_write;
		@(posedge clk) disable iff (rst)
		(do_wr && app == APP_UART && ofs == UA_OFS_SCR) |=> scr_r == $past(wbyte);
	endproperty
	a_scr_write: assert property (p_scr_write) else $error("scratch write lost");

	property p_tx_load;
		@(posedge clk) disable iff (rst)
		(do_wr && app == APP_UART && ofs == UA_OFS_HOLD && !dlab)
			|=> tx_load && tx_data == $past(wbyte);
	endproperty
	a_tx_load: assert property (p_tx_load) else $error("transmit load missing");

	property p_dll;
		@(posedge clk) disable iff (rst)
		(do_wr && app == APP_UART && ofs == UA_OFS_HOLD && dlab)
			|=> !tx_load ##1 divisor[7:0] == $past(wbyte, 2);
	endproperty
	a_dll: assert property (p_dll) else $error("divisor low not written");

	property p_dlm;
		@(posedge clk) disable iff (rst)
		(do_wr && app == APP_UART && ofs == UA_OFS_IEN && dlab)
			|=> ##1 divisor[15:8] == $past(wbyte, 2);
	endproperty
	a_dlm: assert property (p_dlm) else $error("divisor high not written");

	property p_stall_hold;
		@(posedge clk) disable iff (rst)
		(state_r == ST_EXEC && !known) |=> reply_stall && $stable(scr_r) && $stable(line_r);
	endproperty
	a_stall_hold: assert property (p_stall_hold) else $error("unknown request changed state");

	property p_reply_time;
		@(posedge clk) disable iff (rst)
		(state_r == ST_IDLE && setup_valid) |-> ##2 reply_valid;
	endproperty
	a_reply_time: assert property (p_reply_time) else $error("reply not after two cycles");

	property p_fifo_ctl;
		@(posedge clk) disable iff (rst)
		(do_wr && app == APP_UART && ofs == UA_OFS_FIID) |=> fifo_ctl_load && !tx_load;
	endproperty
	a_fifo_ctl: assert property (p_fifo_ctl) else $error("fifo control not loaded");

	property p_lstat_wr;
		@(posedge clk) disable iff (rst)
		(do_wr && app == APP_UART && ofs == UA_OFS_LSTAT) |=> lstat_w_r == $past(wbyte);
	endproperty
	a_lstat_wr: assert property (p_lstat_wr) else $error("line status shadow lost");

	property p_mstat_wr;
		@(posedge clk) disable iff (rst)
		(do_wr && app == APP_UART && ofs == UA_OFS_MSTAT) |=> mstat_w_r == $past(wbyte);
	endproperty
	a_mstat_wr: assert property (p_mstat_wr) else $error("modem status shadow lost");

	property p_pp_ext_wr;
		@(posedge clk) disable iff (rst)
		(do_wr && app == APP_PRINTER && ofs == PP_OFS_EXT) |=> pp_ext_r == $past(wbyte);
	endproperty
	a_pp_ext_wr: assert property (p_pp_ext_wr) else $error("printer write lost");

	property p_ct_clock_wr;
		@(posedge clk) disable iff (rst)
		(do_wr && app == APP_CONTROL && ofs == CT_OFS_CLOCK) |=> ct_clock_r == $past(wbyte);
	endproperty
	a_ct_clock_wr: assert property (p_ct_clock_wr) else $error("control write lost");

	property p_ien_wr;
		@(posedge clk) disable iff (rst)
		(do_wr && app == APP_UART && ofs == UA_OFS_IEN && !dlab)
			|=> ien_r == $past(wbyte) && $stable(divisor_r);
	endproperty
	a_ien_wr: assert property (p_ien_wr) else $error("interrupt enable write lost");

	property p_rx_read;
		@(posedge clk) disable iff (rst)
		(state_r == ST_EXEC && is_read && known && app == APP_UART
			&& ofs == UA_OFS_HOLD && !dlab)
			|=> rx_taken && reply_data == $past(uart_rx_data);
	endproperty
	a_rx_read: assert property (p_rx_read) else $error("receive byte not returned");

	property p_read_ok;
		@(posedge clk) disable iff (rst)
		(state_r == ST_EXEC && is_read && known) |=> reply_valid && !reply_stall;
	endproperty
	a_read_ok: assert property (p_read_ok) else $error("good read stalled");

	property p_ready_pulse;
		@(posedge clk) disable iff (rst)
		setup_ready |=> !setup_ready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");

	property p_stall_regs;
		@(posedge clk) disable iff (rst)
		(state_r == ST_EXEC && !known)
			|=> $stable(pp_data_r) && $stable(divisor_r) && $stable(ct_clock_r) && !tx_load;
	endproperty
	a_stall_regs: assert property (p_stall_regs) else $error("refused request wrote");

	c_read:    cover property (@(posedge clk) reply_valid && !reply_stall && is_read);
	c_write:   cover property (@(posedge clk) tx_load);
	c_stall:   cover property (@(posedge clk) reply_stall);
	c_divisor: cover property (@(posedge clk) do_wr && dlab);
	c_control: cover property (@(posedge clk) do_wr && app == APP_CONTROL);

endmodule // uvr_top

//--- bench/uvr_host_model.sv
/*
 * Host controller model: issues vendor SETUP requests one at a time.
 * Assumes the block answers with setup_ready then reply_valid pulses.
 */
`timescale 1ns/100ps

module uvr_host_model
	import uvr_pkg::*;
(
	// Clock
	input  wire logic       clk,
	// Request to block
	output uvr_setup_type   setup,
	output logic            setup_valid,
	input  wire logic       setup_ready,
	// Answer from block
	input  wire logic       reply_valid,
	input  wire logic       reply_stall,
	input  wire logic [7:0] reply_data
);
	initial begin
		setup = '0;
		setup_valid = 1'b0;
	end

	// ****************************************
	// One control transfer
	// ****************************************
	// Fields built by caller: type, code, value, index, length
	task automatic xfer(input uvr_setup_type s, output logic st, output logic [7:0] d,
		output bit to);
		int n;
		to = 1'b1;
		st = 1'b0;
		d = 8'h00;
		@(negedge clk);
		setup = s;
		setup_valid = 1'b1;
		for (n = 0; n < 20; n++) begin
			@(negedge clk);
			if (setup_ready === 1'b1) break;
		end
		setup_valid = 1'b0;
		// Released fields show a changed pattern
		setup = ~s;
		if (n == 20) return;
		for (n = 0; n < 20; n++) begin
			if (reply_valid === 1'b1) begin
				to = 1'b0;
				st = reply_stall;
				d = reply_data;
				break;
			end
			@(negedge clk);
		end
	endtask
endmodule // uvr_host_model

//--- bench/tb_top.sv
/*
 * Self-checking bench for the vendor register access block.
 * Assumes the host model drives requests; UART status inputs are fixed.
 */
`timescale 1ns/100ps

`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fails++; \
	$display("[FAIL] %0t got %0h exp %0h", $time, (a), (b)); end end

module tb_top;
	import uvr_pkg::*;
	logic          clk, rst;
	uvr_setup_type setup;
	logic          setup_valid, setup_ready, reply_valid, reply_stall;
	logic [7:0]    reply_data, rx_d, ident, lstat, mstat, tx_data, fifo_ctl;
	logic          tx_load, rx_taken, fifo_ctl_load;
	logic [15:0]   divisor;
	int            fails, checked, tx_n, fc_n, rx_n, p, i;
	// Rows: application, offset, byte
	logic [23:0]   rows [13] = '{24'h0100A5, 24'h01015A, 24'h0102C3, 24'h010881,
		24'h010942, 24'h010A24, 24'h02010F, 24'h02031B, 24'h020413, 24'h020777,
		24'h000001, 24'h000102, 24'h000203};

	uvr_top dut (.clk(clk), .rst(rst), .setup(setup), .setup_valid(setup_valid),
		.setup_ready(setup_ready), .reply_valid(reply_valid), .reply_stall(reply_stall),
		.reply_data(reply_data), .uart_rx_data(rx_d), .uart_int_ident(ident),
		.uart_line_status(lstat), .uart_modem_status(mstat), .tx_data(tx_data),
		.tx_load(tx_load), .rx_taken(rx_taken), .divisor(divisor),
		.fifo_ctl(fifo_ctl), .fifo_ctl_load(fifo_ctl_load));

	uvr_host_model host (.clk(clk), .setup(setup), .setup_valid(setup_valid),
		.setup_ready(setup_ready), .reply_valid(reply_valid),
		.reply_stall(reply_stall), .reply_data(reply_data));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// Pulse counters
	always @(posedge clk) begin
		if (tx_load === 1'b1) tx_n++;
		if (fifo_ctl_load === 1'b1) fc_n++;
		if (rx_taken === 1'b1) rx_n++;
	end

	task automatic end_sim;
		if (fails == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ****************************************
	// Request helpers
	// ****************************************
	task automatic raw(input uvr_setup_type s, input bit es, input logic [7:0] ed);
		logic st;
		logic [7:0] d;
		bit to;
		host.xfer(s, st, d, to);
		if (to) begin
			fails++;
			end_sim();
		end else begin
			`CHK(st, es)
			if (s.req_code == REQ_CODE_READ && !es) `CHK(d, ed)
		end
	endtask

	task automatic req(input bit wr, input logic [7:0] app, input logic [15:0] ofs,
		input logic [7:0] b);
		if (wr)
			raw('{REQ_TYPE_WRITE, REQ_CODE_WRITE, {app, b}, ofs, LEN_WRITE}, 1'b0, b);
		else
			raw('{REQ_TYPE_READ, REQ_CODE_READ, {app, 8'h00}, ofs, LEN_READ}, 1'b0, b);
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		rst = 1'b1;
		rx_d = 8'h3C;
		ident = 8'hC1;
		lstat = 8'h60;
		mstat = 8'hB0;
		repeat (4) @(negedge clk);
		rst = 1'b0;
		`CHK(reply_valid, 1'b0)
		`CHK(divisor, RST_DIVISOR)
		// Pass 0 reset reads, pass 1 writes, pass 2 read back
		for (p = 0; p < 3; p++)
			for (i = 0; i < 13; i++)
				req(p == 1, rows[i][23:16], {8'h00, rows[i][15:8]},
					(p == 0) ? RST_BYTE : rows[i][7:0]);
		req(1, APP_UART, UA_OFS_LINE, 8'h80);
		req(1, APP_UART, UA_OFS_HOLD, 8'h34);
		req(1, APP_UART, UA_OFS_IEN, 8'h12);
		req(0, APP_UART, UA_OFS_HOLD, 8'h34);
		req(0, APP_UART, UA_OFS_IEN, 8'h12);
		@(negedge clk);
		`CHK(divisor, 16'h1234)
		req(1, APP_UART, UA_OFS_LINE, 8'h1B);
		req(0, APP_UART, UA_OFS_IEN, 8'h0F);
		req(1, APP_UART, UA_OFS_HOLD, 8'h5A);
		`CHK(tx_data, 8'h5A)
		req(0, APP_UART, UA_OFS_HOLD, 8'h3C);
		req(1, APP_UART, UA_OFS_FIID, 8'h07);
		`CHK(fifo_ctl, 8'h07)
		req(0, APP_UART, UA_OFS_FIID, 8'hC1);
		req(1, APP_UART, UA_OFS_LSTAT, 8'hFF);
		req(1, APP_UART, UA_OFS_MSTAT, 8'hEE);
		req(0, APP_UART, UA_OFS_LSTAT, 8'h60);
		req(0, APP_UART, UA_OFS_MSTAT, 8'hB0);
		@(negedge clk);
		`CHK(divisor, 16'h1234)
		// Refused requests leave registers alone
		raw('{REQ_TYPE_READ, REQ_CODE_WRITE, 16'h0100, 16'h0000, LEN_READ}, 1, 0);
		raw('{REQ_TYPE_WRITE, REQ_CODE_WRITE, 16'h0799, 16'h0007, LEN_READ}, 1, 0);
		raw('{REQ_TYPE_READ, REQ_CODE_READ, 16'h0200, 16'h0007, LEN_WRITE}, 1, 0);
		raw('{REQ_TYPE_WRITE, REQ_CODE_WRITE, 16'h0399, 16'h0000, LEN_WRITE}, 1, 0);
		raw('{REQ_TYPE_WRITE, REQ_CODE_WRITE, 16'h0199, 16'h0100, LEN_WRITE}, 1, 0);
		raw('{REQ_TYPE_WRITE, REQ_CODE_WRITE, 16'h0199, 16'h000B, LEN_WRITE}, 1, 0);
		raw('{REQ_TYPE_WRITE, REQ_CODE_WRITE, 16'h0299, 16'h0008, LEN_WRITE}, 1, 0);
		raw('{REQ_TYPE_READ, REQ_CODE_READ, 16'h0000, 16'h0003, LEN_READ}, 1, 0);
		req(0, APP_PRINTER, PP_OFS_DATA, 8'hA5);
		req(0, APP_UART, UA_OFS_SCR, 8'h77);
		`CHK(tx_n, 1)
		`CHK(fc_n, 1)
		`CHK(rx_n, 1)
		// Reset in mid-run
		rst = 1'b1;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		`CHK(divisor, RST_DIVISOR)
		`CHK(tx_data, RST_BYTE)
		`CHK(fifo_ctl, RST_BYTE)
		req(0, APP_PRINTER, PP_OFS_DATA, RST_BYTE);
		end_sim();
	end
endmodule // tb_top
